/* File: inc/tcs_map.svh */
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH
`define TCS_CODE_TEMP 8'h70
`define TCS_CODE_SETLD 8'h45
`define TCS_LEN_ONE 8'h01
`define TCS_SET_FACTORY 8'h00
`define TCS_SET_USER_LAST 8'h0f
`define TCS_SET_NONE 8'hff
`define TCS_NUM_SETS 16
`define TCS_CFG_W 32
`define TCS_PULSE_COUNT 3'h6
`define TCS_LAMP_TICK_MS 100
`define TCS_CLK_KHZ 40000
`define TCS_LAMP_TICK_CYC (`TCS_LAMP_TICK_MS * `TCS_CLK_KHZ)
`define TCS_LAMP_SLOTS 5'h10
`endif

/* File: inc/tcs_pkg.sv */
package tcs_pkg;
  typedef enum logic [2:0] {
    TCS_IDLE = 3'b001,
    TCS_COPY = 3'b010,
    TCS_RESP = 3'b100
  } tcs_state_t;
endpackage

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic i_sys_clk = 0, i_rst_n = 0, i_cmd_valid, i_cmd_read, o_cmd_ready, o_rsp_valid, o_rsp_read;
  logic o_work_load, o_lamp_yellow;
  logic [7:0] i_command_code, i_cmd_len, i_cmd_data, o_rsp_code, o_rsp_len, o_rsp_data;
  logic [7:0] i_temp_c = 0, cur = 8'hff;
  logic [511:0] i_set_data;
  logic [15:0] i_set_valid = 16'hffdf;
  logic [31:0] o_work_set;
  logic [39:0] q[$];
  int n_errors = 0, n_tests = 0, rises = 0;
  tcs_host host (.i_sys_clk(i_sys_clk), .i_cmd_ready(o_cmd_ready),
    .o_cmd({i_cmd_valid, i_command_code, i_cmd_read, i_cmd_len, i_cmd_data}));
  tcs_cmd #(.LAMP_TICK_CYC(4)) dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
    .i_command_code(i_command_code), .i_cmd_read(i_cmd_read), .i_cmd_len(i_cmd_len), .i_cmd_data(i_cmd_data),
    .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_code(o_rsp_code), .o_rsp_read(o_rsp_read),
    .o_rsp_len(o_rsp_len), .o_rsp_data(o_rsp_data), .i_temp_c(i_temp_c), .i_set_data(i_set_data),
    .i_set_valid(i_set_valid), .o_work_set(o_work_set), .o_work_load(o_work_load), .o_lamp_yellow(o_lamp_yellow));
  task automatic check(input string n, input logic [39:0] s, e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic ask(input logic [7:0] k, e);
    q.push_back({k, 8'h00, 8'h01, 8'h00, e});
    host.send({k, 9'h101, 8'h00});
  endtask
  initial forever #12.5 i_sys_clk = ~i_sys_clk;
  always @(posedge o_lamp_yellow) rises++;
  always @(posedge i_sys_clk) begin
    #2;
    if (o_rsp_valid === 1'b1)
      check("reply", {o_rsp_code, 7'h0, o_rsp_read, o_rsp_len, 8'h0, o_rsp_data}, q.pop_front());
    if (o_work_load === 1'b1)
      check("work set", {8'hff, o_work_set}, q.pop_front());
  end
  initial begin
    repeat (3000) @(posedge i_sys_clk);
    n_errors++;
    test_done();
  end
  initial begin
    void'($urandom(88817));
    for (int i = 0; i < 16; i++) i_set_data[i*32+:32] = $urandom();
    repeat (5) @(posedge i_sys_clk);
    #1 i_rst_n = 1;
    ask(8'h45, cur);
    rises = 0;
    repeat (64) @(posedge i_sys_clk);
    #1 check("pulses", 40'(rises), 40'd6);
    for (int i = 0; i < 3; i++) begin
      i_temp_c = i == 0 ? 8'hec : i == 1 ? 8'h64 : 8'($urandom());
      repeat (3) @(posedge i_sys_clk);
      ask(8'h70, i_temp_c);
    end
    for (int i = 0; i < 16; i++) begin
      if (i_set_valid[i]) q.push_back({8'hff, i_set_data[i*32+:32]});
      if (i_set_valid[i]) cur = 8'(i);
      host.send({8'h45, 9'h001, 8'(i)});
      ask(8'h45, cur);
    end
    host.send({8'h45, 9'h001, 8'h10 | 8'($urandom())});
    host.send({8'h70, 9'h102, 8'h00});
    host.send({8'h70, 9'h001, 8'h00});
    ask(8'h45, cur);
    repeat (4) @(posedge i_sys_clk);
    #1 i_rst_n = 0;
    repeat (2) @(posedge i_sys_clk);
    #1 i_rst_n = 1;
    ask(8'h45, 8'hff);
    repeat (4) @(posedge i_sys_clk);
    check("queue", 40'(q.size()), 40'd0);
    test_done();
  end
endmodule

/* File: verif/tcs_chk_sva.sv */
`timescale 1ns/10ps
module tcs_chk (
  // Inputs
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_command_code,
  input wire logic i_cmd_read,
  input wire logic [7:0] i_cmd_len,
  input wire logic [7:0] i_cmd_data,
  input wire logic [15:0] i_set_valid,
  // Outputs
  input wire logic o_cmd_ready,
  input wire logic o_rsp_valid,
  input wire logic [7:0] o_rsp_code,
  input wire logic o_work_load,
  input wire logic o_lamp_yellow
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire t = i_cmd_valid & o_cmd_ready & (i_cmd_len == 8'h01);
  wire m = i_command_code == 8'h70;
  wire s = i_command_code == 8'h45;
  wire w = t & s & !i_cmd_read;
  property p_a; t & i_cmd_read & m |=> o_rsp_valid & (o_rsp_code == 8'h70); endproperty
  a_a: assert property (p_a) else $error("temp");
  property p_b; t & i_cmd_read & s |=> o_rsp_valid & (o_rsp_code == 8'h45); endproperty
  a_b: assert property (p_b) else $error("set");
  property p_c; t & i_cmd_read & (m | s) |=> !o_cmd_ready [*2] ##1 o_cmd_ready; endproperty
  a_c: assert property (p_c) else $error("gap");
  property p_d; w & (i_cmd_data < 8'h10) & i_set_valid[i_cmd_data[3:0]] |-> ##2 o_work_load; endproperty
  a_d: assert property (p_d) else $error("load");
  property p_e; w |=> !o_rsp_valid; endproperty
  a_e: assert property (p_e) else $error("silent");
  property p_f; w & (i_cmd_data > 8'h0f) |=> o_cmd_ready & !o_work_load; endproperty
  a_f: assert property (p_f) else $error("bad id");
  property p_g; o_rsp_valid |=> !o_rsp_valid; endproperty
  a_g: assert property (p_g) else $error("pulse");
  property p_h; o_work_load |-> ##2 !o_lamp_yellow [*8]; endproperty
  a_h: assert property (p_h) else $error("lamp");
  c_a: cover property (t & m);
  c_b: cover property (o_work_load);
  c_c: cover property (w & (i_cmd_data > 8'h0f));
endmodule
bind tcs_cmd tcs_chk u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
  .i_command_code(i_command_code), .i_cmd_read(i_cmd_read), .i_cmd_len(i_cmd_len), .i_cmd_data(i_cmd_data),
  .i_set_valid(i_set_valid), .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_code(o_rsp_code),
  .o_work_load(o_work_load), .o_lamp_yellow(o_lamp_yellow));

/* File: verif/tcs_host.sv */
`timescale 1ns/10ps
module tcs_host (
  // Clock and handshake
  input wire logic i_sys_clk,
  input wire logic i_cmd_ready,
  // Command frame: valid, code, read, length, data
  output logic [25:0] o_cmd
);
  initial o_cmd = '0;
  // Frame held until taken, released lines scrambled
  task automatic send(input logic [24:0] f);
    @(posedge i_sys_clk) #1;
    o_cmd = {1'b1, f};
    while (!i_cmd_ready) @(posedge i_sys_clk) #1;
    @(posedge i_sys_clk) #1;
    o_cmd = {1'b0, ~f};
  endtask
endmodule

/* File: verilog/tcs_cmd.sv */
`timescale 1ns/10ps
`include "tcs_map.svh"
module tcs_cmd
  import tcs_pkg::*;
#(
  parameter int unsigned LAMP_TICK_CYC = `TCS_LAMP_TICK_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Command in
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_command_code,
  input wire logic i_cmd_read,
  input wire logic [7:0] i_cmd_len,
  input wire logic [7:0] i_cmd_data,
  output logic o_cmd_ready,
  // Response out
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_code,
  output logic o_rsp_read,
  output logic [7:0] o_rsp_len,
  output logic [7:0] o_rsp_data,
  // Temperature sensor, signed degrees C
  input wire logic signed [7:0] i_temp_c,
  // Stored set contents and validity
  input wire logic [`TCS_NUM_SETS*`TCS_CFG_W-1:0] i_set_data,
  input wire logic [`TCS_NUM_SETS-1:0] i_set_valid,
  // Working set
  output logic [`TCS_CFG_W-1:0] o_work_set,
  output logic o_work_load,
  // Indicator
  output logic o_lamp_yellow
);
  tcs_state_t state_q;
  logic [7:0] active_id_q;
  logic [3:0] sel_q;
  logic [7:0] temp_s1_q;
  logic [7:0] temp_s2_q;
  logic [7:0] temp_s3_q;
  logic [7:0] temp_val_q;
  logic [7:0] rsp_data_d;
  logic [7:0] rsp_code_d;
  logic do_rsp;
  logic do_load;
  logic [`TCS_CFG_W-1:0] sets [`TCS_NUM_SETS];

  function automatic logic id_ok(input logic [7:0] id);
    id_ok = (id <= `TCS_SET_USER_LAST);
  endfunction

  genvar g;
  generate
    for (g = 0; g < `TCS_NUM_SETS; g++) begin : g_sets
      assign sets[g] = i_set_data[g*`TCS_CFG_W +: `TCS_CFG_W];
    end
  endgenerate

  // Temperature input crosses from the sensor, two flops
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      temp_s1_q <= 8'h00;
      temp_s2_q <= 8'h00;
    end else begin
      temp_s1_q <= i_temp_c;
      temp_s2_q <= temp_s1_q;
    end
  end

  // Byte taken only once two samples agree, so a torn word is never answered
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      temp_s3_q <= 8'h00;
      temp_val_q <= 8'h00;
    end else begin
      temp_s3_q <= temp_s2_q;
      if (temp_s2_q == temp_s3_q) begin
        temp_val_q <= temp_s2_q;
      end
    end
  end

  // Command decode
  always_comb begin
    do_rsp = 1'b0;
    do_load = 1'b0;
    rsp_code_d = i_command_code;
    rsp_data_d = 8'h00;
    if (i_cmd_valid && o_cmd_ready && i_cmd_len == `TCS_LEN_ONE) begin
      if (i_command_code == `TCS_CODE_TEMP && i_cmd_read) begin
        do_rsp = 1'b1;
        rsp_data_d = temp_val_q;
      end else if (i_command_code == `TCS_CODE_SETLD && i_cmd_read) begin
        do_rsp = 1'b1;
        rsp_data_d = active_id_q;
      end else if (i_command_code == `TCS_CODE_SETLD && !i_cmd_read) begin
        do_load = id_ok(i_cmd_data) && i_set_valid[i_cmd_data[3:0]];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= TCS_IDLE;
      sel_q <= 4'h0;
    end else begin
      case (state_q)
        TCS_IDLE: begin
          if (do_load) begin
            state_q <= TCS_COPY;
            sel_q <= i_cmd_data[3:0];
          end else if (do_rsp) begin
            state_q <= TCS_RESP;
          end
        end
        TCS_COPY: state_q <= TCS_IDLE;
        TCS_RESP: state_q <= TCS_IDLE;
        default: state_q <= TCS_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd_ready <= 1'b1;
    end else begin
      o_cmd_ready <= (state_q == TCS_IDLE) && !do_load && !do_rsp;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_code <= 8'h00;
      o_rsp_read <= 1'b0;
      o_rsp_len <= 8'h00;
      o_rsp_data <= 8'h00;
    end else begin
      o_rsp_valid <= do_rsp;
      if (do_rsp) begin
        o_rsp_code <= rsp_code_d;
        o_rsp_read <= 1'b0;
        o_rsp_len <= `TCS_LEN_ONE;
        o_rsp_data <= rsp_data_d;
      end
    end
  end

  // Copy into working set, active two cycles after the load command is taken
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_work_set <= '0;
      o_work_load <= 1'b0;
      active_id_q <= `TCS_SET_NONE;
    end else begin
      o_work_load <= (state_q == TCS_COPY);
      if (state_q == TCS_COPY) begin
        o_work_set <= sets[sel_q];
        active_id_q <= {4'h0, sel_q};
      end
    end
  end

  tcs_lamp #(
    .TICK_CYC(LAMP_TICK_CYC)
  ) u_lamp (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_enable(active_id_q == `TCS_SET_NONE),
    .o_lamp(o_lamp_yellow)
  );
endmodule

/* File: verilog/tcs_lamp.sv */
`timescale 1ns/10ps
`include "tcs_map.svh"
module tcs_lamp #(
  parameter int unsigned TICK_CYC = `TCS_LAMP_TICK_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_enable,
  // Lamp
  output logic o_lamp
);
  logic [31:0] tick_cnt_q;
  logic tick_q;
  logic [4:0] slot_q;
  logic [3:0] slot_half;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slot_q <= 5'h0;
    end else if (!i_enable) begin
      slot_q <= 5'h0;
    end else if (tick_q) begin
      slot_q <= (slot_q == `TCS_LAMP_SLOTS - 5'h1) ? 5'h0 : slot_q + 5'h1;
    end
  end

  assign slot_half = slot_q[4:1];

  // Six pulses, then a pause, repeating
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_lamp <= 1'b0;
    end else begin
      o_lamp <= i_enable && !slot_q[0] && (slot_half < {1'b0, `TCS_PULSE_COUNT});
    end
  end
endmodule
